// File: css_pkg.sv
// Package of constants for the capacitive sense scan controller
package css_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_CONFIG    = 8'h04;
  localparam logic [7:0] OFS_CHANNEL   = 8'h08;
  localparam logic [7:0] OFS_SCAN_BEG  = 8'h0c;
  localparam logic [7:0] OFS_SCAN_END  = 8'h10;
  localparam logic [7:0] OFS_THRESHOLD = 8'h14;
  localparam logic [7:0] OFS_RESULT    = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h1c;
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE   = 7;
  localparam int CTL_COMPLETE = 5;
  localparam int CTL_BUSY     = 4;
  localparam int CTL_ABOVE    = 0;
  localparam int CFG_SRC_LO   = 4;
  localparam int CFG_ACC_LO   = 0;
  localparam int IEN_COMPLETE = 0;
  localparam int IEN_GREATER  = 1;
  localparam int CH_W         = 5;
  localparam int DATA_W       = 16;
  localparam int SUM_W        = 20;
  // ----------------------------------------------------------------
  // Start sources and accumulate counts
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_SOFT   = 3'h0;
  localparam logic [2:0] SRC_TMR0   = 3'h1;
  localparam logic [2:0] SRC_TMR2   = 3'h2;
  localparam logic [2:0] SRC_TMR1   = 3'h3;
  localparam logic [2:0] SRC_TMR3   = 3'h4;
  localparam logic [2:0] SRC_CONT   = 3'h6;
  localparam logic [2:0] SRC_SCAN   = 3'h7;
  localparam logic [1:0] ACC_X1     = 2'h0;
  localparam logic [1:0] ACC_X4     = 2'h1;
  localparam logic [1:0] ACC_X8     = 2'h2;
  localparam logic [3:0] LAST_X1    = 4'h0;
  localparam logic [3:0] LAST_X4    = 4'h3;
  localparam logic [3:0] LAST_X8    = 4'h7;
  localparam logic [3:0] LAST_X16   = 4'hf;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Sequencer states, encoded 0, 1 and 3; WAIT to IDLE changes both bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_START = 2'h1,
    ST_WAIT  = 2'h3
  } css_state_e;
endpackage

// File: css_acc_if.sv
// Interface between sequencer and sample accumulator
`timescale 1ns/1ps
`default_nettype none
interface css_acc_if;
  logic        flush;
  logic        sample_valid;
  logic [15:0] sample;
  logic [1:0]  acc_sel;
  logic        last;
  logic        result_valid;
  logic [15:0] result;
  modport seq (output flush, sample_valid, sample, acc_sel,
               input last, result_valid, result);
  modport acc (input flush, sample_valid, sample, acc_sel,
               output last, result_valid, result);
endinterface // css_acc_if
`default_nettype wire

// File: css_accum.sv
// Sample accumulator with divide by sample count
`timescale 1ns/1ps
`default_nettype none
module css_accum (
  input  wire logic pclk,
  input  wire logic presetn,
  css_acc_if.acc    bus
);
  logic [19:0] sum;
  logic [3:0]  cnt;
  logic [3:0]  last_idx;
  logic [19:0] sum_n;
  logic [19:0] quot;

  assign last_idx = (bus.acc_sel == css_pkg::ACC_X1) ? css_pkg::LAST_X1 :
                    (bus.acc_sel == css_pkg::ACC_X4) ? css_pkg::LAST_X4 :
                    (bus.acc_sel == css_pkg::ACC_X8) ? css_pkg::LAST_X8 :
                                                       css_pkg::LAST_X16;
  assign sum_n    = sum + {4'h0, bus.sample};
  assign quot     = (bus.acc_sel == css_pkg::ACC_X1) ? sum_n :
                    (bus.acc_sel == css_pkg::ACC_X4) ? (sum_n >> 2) :
                    (bus.acc_sel == css_pkg::ACC_X8) ? (sum_n >> 3) :
                                                       (sum_n >> 4);
  assign bus.last = (cnt == last_idx);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum              <= 20'h0_0000;
      cnt              <= 4'h0;
      bus.result_valid <= 1'b0;
      bus.result       <= 16'h0000;
    end else if (bus.flush) begin
      sum              <= 20'h0_0000;
      cnt              <= 4'h0;
      bus.result_valid <= 1'b0;
    end else begin
      bus.result_valid <= bus.sample_valid && bus.last;
      if (bus.sample_valid && bus.last) begin
        sum        <= 20'h0_0000;
        cnt        <= 4'h0;
        bus.result <= quot[15:0];
      end else if (bus.sample_valid) begin
        sum <= sum_n;
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // css_accum
`default_nettype wire

// File: css_scan_ctrl.sv
// Capacitive sense scan controller with APB register slave
`timescale 1ns/1ps
`default_nettype none
module css_scan_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [3:0]  tmr_ovf,
  input  wire logic        suspend,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  output var  logic        conv_start,
  output var  logic [4:0]  channel,
  output var  logic        unit_powered,
  output var  logic        irq_complete,
  output var  logic        irq_greater,
  output var  logic        wake
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        enable;
  logic        complete;
  logic        busy;
  logic        above;
  logic [2:0]  src;
  logic [1:0]  acc_sel;
  logic [4:0]  scan_beg;
  logic [4:0]  scan_end;
  logic [15:0] threshold;
  logic [15:0] result;
  logic [1:0]  irq_en;
  logic        run;
  logic [3:0]  tmr_q;
  css_pkg::css_state_e state;
  css_pkg::css_state_e next_state;
  css_acc_if acc ();

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access   = psel && penable && pready;
  wire wr       = access && pwrite;
  wire wr_ctl   = wr && (paddr == css_pkg::OFS_CONTROL);
  wire wr_cfg   = wr && (paddr == css_pkg::OFS_CONFIG);
  wire wr_chn   = wr && (paddr == css_pkg::OFS_CHANNEL);
  wire wr_beg   = wr && (paddr == css_pkg::OFS_SCAN_BEG);
  wire wr_end   = wr && (paddr == css_pkg::OFS_SCAN_END);
  wire wr_thr   = wr && (paddr == css_pkg::OFS_THRESHOLD);
  wire wr_ien   = wr && (paddr == css_pkg::OFS_IRQ_EN);
  wire mapped   = (paddr == css_pkg::OFS_CONTROL) ||
                  (paddr == css_pkg::OFS_CONFIG) ||
                  (paddr == css_pkg::OFS_CHANNEL) ||
                  (paddr == css_pkg::OFS_SCAN_BEG) ||
                  (paddr == css_pkg::OFS_SCAN_END) ||
                  (paddr == css_pkg::OFS_THRESHOLD) ||
                  (paddr == css_pkg::OFS_RESULT) ||
                  (paddr == css_pkg::OFS_IRQ_EN);
  wire [31:0] ctl_word = {24'h00_0000, enable, 1'b0, complete, busy,
                          3'h0, above};
  wire [31:0] rd_word  =
    (paddr == css_pkg::OFS_CONTROL)   ? ctl_word :
    (paddr == css_pkg::OFS_CONFIG)    ? {25'h000_0000, src, 2'h0,
                                         acc_sel} :
    (paddr == css_pkg::OFS_CHANNEL)   ? {27'h000_0000, channel} :
    (paddr == css_pkg::OFS_SCAN_BEG)  ? {27'h000_0000, scan_beg} :
    (paddr == css_pkg::OFS_SCAN_END)  ? {27'h000_0000, scan_end} :
    (paddr == css_pkg::OFS_THRESHOLD) ? {16'h0000, threshold} :
    (paddr == css_pkg::OFS_RESULT)    ? {16'h0000, result} :
    (paddr == css_pkg::OFS_IRQ_EN)    ? {30'h0000_0000, irq_en} :
                                        css_pkg::RESET_WORD;

  // ----------------------------------------------------------------
  // Start decode
  // ----------------------------------------------------------------
  // auto-scan select
  wire scan_mode = (src == css_pkg::SRC_SCAN);
  wire cont_mode = scan_mode || (src == css_pkg::SRC_CONT);
  wire busy_wr1  = wr_ctl && pwdata[css_pkg::CTL_BUSY];
  wire [3:0] tmr_edge = tmr_ovf & ~tmr_q;
  wire tmr_req   = ((src == css_pkg::SRC_TMR0) && tmr_edge[0]) ||
                   ((src == css_pkg::SRC_TMR1) && tmr_edge[1]) ||
                   ((src == css_pkg::SRC_TMR2) && tmr_edge[2]) ||
                   ((src == css_pkg::SRC_TMR3) && tmr_edge[3]);
  wire soft_req  = (src == css_pkg::SRC_SOFT) && busy_wr1;
  wire idle      = (state == css_pkg::ST_IDLE) && !busy;
  wire start_req = enable && idle && (soft_req || tmr_req || run);
  wire res_v     = acc.result_valid;
  wire gt        = acc.result > threshold;
  wire at_end    = (channel == scan_end);

  assign acc.flush        = !enable;
  assign acc.sample_valid = (state == css_pkg::ST_WAIT) && conv_done;
  assign acc.sample       = conv_data;
  assign acc.acc_sel      = acc_sel;

  css_accum u_accum (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (acc)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      css_pkg::ST_IDLE: begin
        if (start_req) next_state = css_pkg::ST_START;
      end
      css_pkg::ST_START: begin
        next_state = css_pkg::ST_WAIT;
      end
      css_pkg::ST_WAIT: begin
        if (conv_done && acc.last) next_state = css_pkg::ST_IDLE;
        else if (conv_done) next_state = css_pkg::ST_START;
      end
      default: next_state = css_pkg::ST_IDLE;
    endcase
    if (!enable) next_state = css_pkg::ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= css_pkg::ST_IDLE;
      conv_start <= 1'b0;
      tmr_q      <= 4'h0;
    end else begin
      state      <= next_state;
      conv_start <= (next_state == css_pkg::ST_START);
      tmr_q      <= tmr_ovf;
    end
  end

  // ----------------------------------------------------------------
  // Busy, run and flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      run  <= 1'b0;
    end else begin
      if (!enable || res_v) busy <= 1'b0;
      else if (start_req) busy <= 1'b1;
      if (!enable || !cont_mode || (scan_mode && res_v && gt)) begin
        run <= 1'b0;
      end else if (busy_wr1) begin
        run <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complete <= 1'b0;
      above    <= 1'b0;
      result   <= 16'h0000;
    end else begin
      if (res_v) complete <= 1'b1;
      else if (wr_ctl && !pwdata[css_pkg::CTL_COMPLETE]) complete <= 1'b0;
      if (res_v) begin
        above  <= gt;
        result <= acc.result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel select
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel <= 5'h00;
    end else if (wr_beg && scan_mode) begin
      channel <= pwdata[4:0];
    end else if (wr_chn) begin
      channel <= pwdata[4:0];
    end else if (scan_mode && res_v && !gt) begin
      channel <= at_end ? scan_beg : channel + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable    <= 1'b0;
      src       <= css_pkg::SRC_SOFT;
      acc_sel   <= css_pkg::ACC_X1;
      scan_beg  <= 5'h00;
      scan_end  <= 5'h00;
      threshold <= 16'h0000;
      irq_en    <= 2'h0;
    end else begin
      if (wr_ctl) enable <= pwdata[css_pkg::CTL_ENABLE];
      if (wr_cfg) src <= pwdata[css_pkg::CFG_SRC_LO +: 3];
      if (wr_cfg) acc_sel <= pwdata[css_pkg::CFG_ACC_LO +: 2];
      if (wr_beg) scan_beg <= pwdata[4:0];
      if (wr_end) scan_end <= pwdata[4:0];
      if (wr_thr) threshold <= pwdata[15:0];
      if (wr_ien) irq_en <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs and APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_powered <= 1'b0;
      irq_complete <= 1'b0;
      irq_greater  <= 1'b0;
      wake         <= 1'b0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= css_pkg::RESET_WORD;
    end else begin
      unit_powered <= enable;
      irq_complete <= complete && irq_en[css_pkg::IEN_COMPLETE];
      irq_greater  <= above && irq_en[css_pkg::IEN_GREATER];
      wake         <= suspend && res_v && gt;
      pready       <= psel && !penable && !pready;
      pslverr      <= psel && !penable && !pready && !mapped;
      if (psel && !penable) prdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_final;
    (state == css_pkg::ST_WAIT) && conv_done && acc.last;
  endsequence
  sequence s_report;
    ##1 res_v ##1 (complete && !busy);
  endsequence

  a_disabled_idle: assert property (
    !enable |=> (state == css_pkg::ST_IDLE) && !conv_start)
    else $error("conversion activity while disabled");
  a_soft_start: assert property (
    enable && idle && (src == css_pkg::SRC_SOFT) && busy_wr1
    |=> conv_start && busy)
    else $error("software start did not begin conversion");
  a_final_report: assert property (
    s_final |-> s_report)
    else $error("completion not reported after final sample");
  a_no_early_done: assert property (
    (state == css_pkg::ST_WAIT) && conv_done && !acc.last |=> !res_v)
    else $error("completion before final sample");
  a_scan_copy: assert property (
    wr_beg && scan_mode |=> channel == $past(pwdata[4:0]))
    else $error("scan start not copied to channel");
  a_scan_step: assert property (
    scan_mode && res_v && !gt && !at_end && !wr_beg && !wr_chn
    |=> channel == $past(channel) + 5'h01)
    else $error("auto-scan did not advance");
  a_scan_wrap: assert property (
    scan_mode && res_v && !gt && at_end && !wr_beg && !wr_chn
    |=> channel == $past(scan_beg))
    else $error("auto-scan did not wrap");
  a_above_flag: assert property (
    res_v |=> above == (result > $past(threshold)))
    else $error("above-threshold flag wrong");
  a_gt_halt: assert property (
    scan_mode && res_v && gt |=> !run && (state == css_pkg::ST_IDLE))
    else $error("auto-scan kept running after greater-than");
  a_busy_span: assert property (
    conv_start |-> busy)
    else $error("busy low during conversion");
  a_cont_wait: assert property (
    cont_mode && !run && idle |=> !conv_start)
    else $error("continuous mode started without busy write");
  a_wake_gt: assert property (
    suspend && res_v && gt |=> wake)
    else $error("no wake on greater-than in suspend");
endmodule // css_scan_ctrl
`default_nettype wire

// File: css_conv_model.sv
// Converter model answering start pulses with samples
`timescale 1ns/1ps
`default_nettype none
module css_conv_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_start,
  input  wire logic        slow,
  input  wire logic [15:0] base,
  output var  logic        conv_done,
  output var  logic [15:0] conv_data
);
  logic [3:0] wait_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt  <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      // Data not valid outside the done pulse
      conv_data <= ~conv_data;
      if (conv_start) begin
        wait_cnt <= slow ? 4'h9 : 4'h2;
      end else if (wait_cnt == 4'h1) begin
        wait_cnt  <= 4'h0;
        conv_done <= 1'b1;
        conv_data <= base;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule // css_conv_model
`default_nettype wire

// File: cap_sense_scan_control_tb_top.sv
// Self-checking bench of the scan controller
`timescale 1ns/1ps
`default_nettype none
module cap_sense_scan_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, suspend;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] tmr_ovf;
  logic conv_done, conv_start, unit_powered, irq_complete, irq_greater;
  logic wake, slow, comp_q;
  logic [15:0] conv_data, base;
  logic [4:0] channel;
  logic [4:0] chans[$];
  int bad_count, comparisons, starts, wakes, comps;

  css_scan_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr_ovf(tmr_ovf), .suspend(suspend), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start(conv_start), .channel(channel),
    .unit_powered(unit_powered), .irq_complete(irq_complete),
    .irq_greater(irq_greater), .wake(wake));
  css_conv_model model (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .slow(slow), .base(base),
    .conv_done(conv_done), .conv_data(conv_data));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    comp_q <= irq_complete;
    if (conv_start === 1'b1) begin
      starts++;
      chans.push_back(channel);
    end
    if (wake === 1'b1) wakes++;
    if (irq_complete === 1'b1 && comp_q === 1'b0) comps++;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s %h vs %h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(n < 50, 1'b1, "no pready");
    rdv = prdata;
    check(pslverr, a > css_pkg::OFS_IRQ_EN, "pslverr");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(css_pkg::OFS_CONTROL);
      n++;
    end while (rdv[css_pkg::CTL_BUSY] !== 1'b0 && n < 300);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map();
    rd(css_pkg::OFS_CONTROL);
    check(rdv, css_pkg::RESET_WORD, "control reset");
    rd(8'h20);
    check(rdv, 32'h0000_0000, "unmapped read");
    wr(css_pkg::OFS_CHANNEL, 32'h0000_0013);
    cyc(1);
    check(channel, 5'h13, "channel port");
    wr(css_pkg::OFS_CONTROL, 32'h0000_0010);
    cyc(20);
    check(starts, 0, "start while off");
    check(unit_powered, 1'b0, "powered");
  endtask
  task automatic t_soft();
    wr(css_pkg::OFS_IRQ_EN, 32'h0000_0001);
    wr(css_pkg::OFS_THRESHOLD, 32'h0000_0100);
    wr(css_pkg::OFS_CONFIG, 32'h0000_0000);
    wr(css_pkg::OFS_CONTROL, 32'h0000_0090);
    rd(css_pkg::OFS_CONTROL);
    check(rdv[css_pkg::CTL_BUSY], 1'b1, "busy");
    check(unit_powered, 1'b1, "powered on");
    wait_idle();
    check(starts, 1, "soft starts");
    check(rdv, 32'h0000_00a1, "control after");
    rd(css_pkg::OFS_RESULT);
    check(rdv, 32'h0000_0200, "result");
    check(irq_complete, 1'b1, "irq complete");
    check(irq_greater, 1'b0, "irq greater masked");
    wr(css_pkg::OFS_IRQ_EN, 32'h0000_0000);
    wr(css_pkg::OFS_THRESHOLD, 32'h0000_0200);
    wr(css_pkg::OFS_CONTROL, 32'h0000_0090);
    wait_idle();
    check(rdv, 32'h0000_00a0, "equal not above");
    check(irq_complete, 1'b0, "irq masked");
  endtask
  task automatic t_accum();
    int s0, c0;
    for (int a = 0; a < 4; a++) begin
      slow <= a[0];
      wr(css_pkg::OFS_CONTROL, 32'h0000_0080);
      wr(css_pkg::OFS_IRQ_EN, 32'h0000_0001);
      wr(css_pkg::OFS_CONFIG, a);
      s0 = starts;
      c0 = comps;
      wr(css_pkg::OFS_CONTROL, 32'h0000_0090);
      wait_idle();
      rd(css_pkg::OFS_RESULT);
      check(rdv, 32'h0000_0200, "mean");
      check(starts - s0, a == 0 ? 1 : 2 << a, "samples");
      check(comps - c0, 1, "one complete");
    end
  endtask
  task automatic t_timers();
    logic [2:0] src[4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    int bit_of[4] = '{0, 2, 1, 3};
    int s0;
    for (int i = 0; i < 4; i++) begin
      wr(css_pkg::OFS_CONFIG, {src[i], 4'h0});
      s0 = starts;
      tmr_ovf <= 4'h1 << ((bit_of[i] + 1) % 4);
      cyc(3);
      tmr_ovf <= 4'h0;
      cyc(20);
      check(starts - s0, 0, "wrong timer");
      tmr_ovf <= 4'h1 << bit_of[i];
      cyc(30);
      tmr_ovf <= 4'h0;
      wait_idle();
      check(starts - s0, 1, "timer start");
    end
  endtask
  task automatic t_cont();
    int s0;
    s0 = starts;
    wr(css_pkg::OFS_CONFIG, {css_pkg::SRC_CONT, 4'h0});
    cyc(20);
    check(starts - s0, 0, "cont before busy");
    wr(css_pkg::OFS_CONTROL, 32'h0000_0090);
    cyc(100);
    check(starts - s0 >= 3, 1'b1, "back to back");
    wr(css_pkg::OFS_CONTROL, 32'h0000_0000);
    cyc(5);
    s0 = starts;
    cyc(30);
    check(starts - s0, 0, "stop on disable");
    check(unit_powered, 1'b0, "powered off");
  endtask
  task automatic t_scan();
    int s0, n;
    logic [4:0] exp_ch[5] = '{5'h1d, 5'h1e, 5'h1f, 5'h1d, 5'h1e};
    logic [4:0] held;
    wr(css_pkg::OFS_CONTROL, 32'h0000_0080);
    wr(css_pkg::OFS_IRQ_EN, 32'h0000_0003);
    wr(css_pkg::OFS_THRESHOLD, 32'h0000_ffff);
    wr(css_pkg::OFS_CONFIG, {css_pkg::SRC_SCAN, 4'h0});
    wr(css_pkg::OFS_SCAN_END, 32'h0000_001f);
    wr(css_pkg::OFS_SCAN_BEG, 32'h0000_001d);
    cyc(1);
    check(channel, 5'h1d, "scan start copy");
    s0 = starts;
    wr(css_pkg::OFS_CONTROL, 32'h0000_0090);
    n = 0;
    while (starts - s0 < 5 && n < 500) begin
      cyc(1);
      n++;
    end
    for (int k = 0; k < 5; k++)
      check(chans[s0 + k], exp_ch[k], "scan order");
    check(wakes, 0, "no wake awake");
    suspend <= 1'b1;
    wr(css_pkg::OFS_THRESHOLD, 32'h0000_0100);
    n = 0;
    while (wakes == 0 && n < 300) begin
      cyc(1);
      n++;
    end
    check(wakes, 1, "wake");
    held = channel;
    s0 = starts;
    cyc(40);
    check(starts - s0, 0, "scan halted");
    check(channel, held, "channel held");
    check(irq_greater, 1'b1, "irq greater");
    suspend <= 1'b0;
    wr(css_pkg::OFS_CONTROL, 32'h0000_0090);
    cyc(5);
    check(starts - s0 > 0, 1'b1, "restart");
  endtask

  initial begin
    {psel, penable, pwrite, suspend, slow} = 5'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    tmr_ovf = 4'h0;
    base    = 16'h0200;
    presetn = 1'b0;
    cyc(10);
    presetn <= 1'b1;
    t_reset_map();
    wr(css_pkg::OFS_CONTROL, 32'h0000_0080);
    t_soft();
    t_accum();
    t_timers();
    t_cont();
    t_scan();
    summarize();
  end
  initial begin
    cyc(20000);
    bad_count++;
    summarize();
  end
endmodule // cap_sense_scan_control_tb_top
`default_nettype wire
